// File: common/dcs_defines.svh
// Timing and layout constants for the DRAM command spacing link.
// Assumes one memory clock cycle spans eight i_clk cycles (one per eighth).
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH

// Minimum intervals in memory clock cycles, packed bins {A,B,C,D}
`define DCS_T_RW    {6'd8, 6'd9, 6'd9, 6'd10}
`define DCS_T_WR    {6'd9, 6'd10, 6'd10, 6'd10}
`define DCS_T_RDP   {6'd3, 6'd4, 6'd4, 6'd6}
`define DCS_T_WRP   {6'd10, 6'd12, 6'd12, 6'd14}
`define DCS_T_DR    {6'd6, 6'd7, 6'd7, 6'd7}
`define DCS_T_DP    {6'd7, 6'd9, 6'd9, 6'd11}
`define DCS_T_LRR   {6'd16, 6'd20, 6'd24, 6'd24}
`define DCS_T_RC    {6'd16, 6'd20, 6'd24, 6'd30}
`define DCS_T_WR_D  6'd2
`define DCS_T_CC    6'd2
`define DCS_T_CWD   6'd3
`define DCS_CNT_SAT 6'd63

// Link layout
`define DCS_REQ_W       12
`define DCS_PKT_W       24
`define DCS_BITS_PIN    16
`define DCS_OFF_W       3
`define DCS_W1_EIGHTH   3'd4
`define DCS_LAST_EIGHTH 3'd7
// Eighths from command start to write data start (write delay times eight)
`define DCS_DATA_START  6'd24
// Eighths from command start until the latest pin has delivered bit 15
`define DCS_DELIVER     6'd47

`endif

// File: common/dcs_link_if.sv
// Pin bundle between the memory controller and the DRAM device.
// Assumes both ends run on the same i_clk; write direction only.
`timescale 1ns/100ps
`include "dcs_defines.svh"

interface dcs_link_if #(parameter int DW = 16);
	logic                     clock_true_phase;
	logic                     clock_comp_phase;
	logic [`DCS_REQ_W-1:0]    request_pins;
	logic [DW-1:0]            data_true_pins;
	logic [DW-1:0]            data_comp_pins;

	modport ctrl (
		output clock_true_phase,
		output clock_comp_phase,
		output request_pins,
		output data_true_pins,
		output data_comp_pins
	);

	modport dev (
		input  clock_true_phase,
		input  clock_comp_phase,
		input  request_pins,
		input  data_true_pins,
		input  data_comp_pins
	);
endinterface

// File: common/dcs_pkg.sv
// Types shared by both ends of the command link; timing lookup used by the controller end.
// Assumes dcs_defines.svh is on the include path.
`include "dcs_defines.svh"

package dcs_pkg;

	typedef enum logic [1:0] {
		bin_a,
		bin_b,
		bin_c,
		bin_d
	} dcs_bin_type;

	typedef enum logic [3:0] {
		cmd_nop,
		row_activate_cmd,
		column_read_cmd,
		column_write_cmd,
		masked_column_write_cmd,
		row_precharge_cmd,
		refresh_reg_load_0,
		refresh_reg_load_1,
		refresh_reg_load_2,
		refresh_activate_cmd,
		refresh_increment_activate_cmd,
		refresh_precharge_cmd
	} dcs_cmd_type;

	function automatic logic [5:0] dcs_pick(input logic [23:0] tbl, input dcs_bin_type b);
		return tbl[(3 - int'(b)) * 6 +: 6];
	endfunction

	function automatic logic dcs_is_load(input dcs_cmd_type c);
		return c == refresh_reg_load_0 || c == refresh_reg_load_1 || c == refresh_reg_load_2;
	endfunction

	function automatic logic dcs_is_refx(input dcs_cmd_type c);
		return c == refresh_activate_cmd || c == refresh_increment_activate_cmd || c == refresh_precharge_cmd;
	endfunction

	function automatic logic dcs_is_write(input dcs_cmd_type c);
		return c == column_write_cmd || c == masked_column_write_cmd;
	endfunction

endpackage

// File: src/dcs_controller.sv
// Memory controller end: spaces commands per speed bin, drives request
// packets and write data onto the link.
// Assumes the device end shares i_clk; one memory cycle is eight i_clk cycles.
//
// Operation
// - Read to write spacing per bin
// - Write to read spacing; two across sets
// - Cross-set write-read never 3, 5, 7
// - Read to precharge same bank spacing
// - Write to precharge same bank spacing
// - Write data start to read spacing
// - Write data to precharge spacing
// - Load and refresh group spacing
// - Three loads, three refreshes form groups
// - Row cycle minimum on every activate
// - Falling true clock phase is reference
// - Request pins carry inverted logic
// - Device samples requests twice per cycle
// - Write data pins are true logic
// - Sixteen bits per pin, eighth spacing
// - Static per-pin offset within range
// - Same-kind column commands two cycles apart
// - Write data three cycles after command
`timescale 1ns/100ps
`include "dcs_defines.svh"

module dcs_controller
	import dcs_pkg::*;
#(
	parameter int DW = 16
) (
	// Clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	// Static configuration
	input  wire dcs_bin_type            i_bin,
	input  wire logic [DW*3-1:0]        i_tx_offset,
	// Request port
	input  wire logic                   i_req_valid,
	input  wire dcs_cmd_type            i_req_cmd,
	input  wire logic [2:0]             i_req_bank,
	input  wire logic [DW*16-1:0]       i_req_data,
	output logic                        o_req_ready,
	// Link
	dcs_link_if.ctrl                    link
);

	localparam int NB = 8;

	logic [5:0]            ecnt;
	logic                  tick;
	logic [2:0]            next_slot;
	logic [`DCS_PKT_W-1:0] pkt;
	logic [`DCS_PKT_W-1:0] next_pkt;
	logic                  legal;
	logic                  accept;
	logic [NB-1:0]         slot_v;
	logic [DW*16-1:0]      slot_d [NB];

	logic [5:0] since_rd;
	logic [5:0] since_load;
	logic [5:0] since_refx;
	logic [5:0] since_wr_set [2];
	logic [5:0] since_rd_bank [NB];
	logic [5:0] since_wr_bank [NB];
	logic [5:0] since_act_bank [NB];

	logic [5:0] t_rw;
	logic [5:0] t_wr;
	logic [5:0] t_rdp;
	logic [5:0] t_wrp;
	logic [5:0] t_dr;
	logic [5:0] t_dp;
	logic [5:0] t_lrr;
	logic [5:0] t_rc;

	// Whole interval set follows the static bin
	assign t_rw  = dcs_pick(`DCS_T_RW, i_bin);
	assign t_wr  = dcs_pick(`DCS_T_WR, i_bin);
	assign t_rdp = dcs_pick(`DCS_T_RDP, i_bin);
	assign t_wrp = dcs_pick(`DCS_T_WRP, i_bin);
	assign t_dr  = dcs_pick(`DCS_T_DR, i_bin);
	assign t_dp  = dcs_pick(`DCS_T_DP, i_bin);
	assign t_lrr = dcs_pick(`DCS_T_LRR, i_bin);
	assign t_rc  = dcs_pick(`DCS_T_RC, i_bin);

	function automatic logic [5:0] age(input logic [5:0] cnt, input logic hit);
		if (hit) begin
			return 6'd1;
		end
		return (cnt == `DCS_CNT_SAT) ? cnt : 6'(cnt + 6'd1);
	endfunction

	// Cross-set write to read: short spacings of two or more allowed except 3, 5 and 7
	function automatic logic cross_ok(input logic [5:0] x, input logic [5:0] same_min);
		if (x >= same_min) begin
			return 1'b1;
		end
		return x >= `DCS_T_WR_D && x != 6'd3 && x != 6'd5 && x != 6'd7;
	endfunction

	assign tick      = ecnt[2:0] == `DCS_LAST_EIGHTH;
	assign next_slot = 3'(ecnt[5:3] + 3'd1);

	always_comb begin
		logic       s;
		logic [2:0] b;
		s     = i_req_bank[0];
		b     = i_req_bank;
		legal = 1'b1;
		if (i_req_cmd == column_read_cmd) begin
			legal = since_rd >= `DCS_T_CC
				&& since_wr_set[s] >= t_wr
				&& cross_ok(since_wr_set[~s], t_wr)
				&& since_wr_bank[b] >= 6'(t_dr + `DCS_T_CWD);
		end else if (dcs_is_write(i_req_cmd)) begin
			legal = since_wr_set[0] >= `DCS_T_CC && since_wr_set[1] >= `DCS_T_CC
				&& since_rd >= t_rw;
		end else if (i_req_cmd == row_precharge_cmd) begin
			legal = since_rd_bank[b] >= t_rdp
				&& since_wr_bank[b] >= t_wrp
				&& since_wr_bank[b] >= 6'(t_dp + `DCS_T_CWD);
		end else if (dcs_is_load(i_req_cmd)) begin
			legal = since_load >= t_lrr && since_refx >= t_lrr;
		end else if (dcs_is_refx(i_req_cmd)) begin
			legal = since_load >= t_lrr;
			if (i_req_cmd != refresh_precharge_cmd) begin
				legal = legal && since_act_bank[b] >= t_rc;
			end
		end else if (i_req_cmd == row_activate_cmd) begin
			legal = since_act_bank[b] >= t_rc;
		end
	end

	// Commands wait at the cycle boundary until every interval has run out
	assign o_req_ready = tick && legal;
	assign accept      = o_req_ready && i_req_valid;
	assign next_pkt    = accept ? {17'h0, i_req_bank, i_req_cmd} : `DCS_PKT_W'(0);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ecnt <= 6'h00;
		end else begin
			ecnt <= 6'(ecnt + 6'd1);
		end
	end

	// Timestamps counted in memory cycles since each kind of command except row precharge
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			since_rd   <= `DCS_CNT_SAT;
			since_load <= `DCS_CNT_SAT;
			since_refx <= `DCS_CNT_SAT;
			for (int i = 0; i < 2; i++) begin
				since_wr_set[i] <= `DCS_CNT_SAT;
			end
			for (int i = 0; i < NB; i++) begin
				since_rd_bank[i]  <= `DCS_CNT_SAT;
				since_wr_bank[i]  <= `DCS_CNT_SAT;
				since_act_bank[i] <= `DCS_CNT_SAT;
			end
		end else if (tick) begin
			since_rd   <= age(since_rd, accept && i_req_cmd == column_read_cmd);
			since_load <= age(since_load, accept && dcs_is_load(i_req_cmd));
			since_refx <= age(since_refx, accept && dcs_is_refx(i_req_cmd));
			for (int i = 0; i < 2; i++) begin
				since_wr_set[i] <= age(since_wr_set[i],
					accept && dcs_is_write(i_req_cmd) && i_req_bank[0] == 1'(i));
			end
			for (int i = 0; i < NB; i++) begin
				since_rd_bank[i] <= age(since_rd_bank[i],
					accept && i_req_cmd == column_read_cmd && i_req_bank == 3'(i));
				since_wr_bank[i] <= age(since_wr_bank[i],
					accept && dcs_is_write(i_req_cmd) && i_req_bank == 3'(i));
				since_act_bank[i] <= age(since_act_bank[i], accept && i_req_bank == 3'(i)
					&& (i_req_cmd == row_activate_cmd || i_req_cmd == refresh_activate_cmd
					|| i_req_cmd == refresh_increment_activate_cmd));
			end
		end
	end

	// Clock pair: true phase falls entering eighth 0, rises entering eighth 4
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			link.clock_true_phase <= 1'b0;
			link.clock_comp_phase <= 1'b1;
		end else begin
			link.clock_true_phase <= ecnt[2:0] >= 3'd3 && ecnt[2:0] <= 3'd6;
			link.clock_comp_phase <= !(ecnt[2:0] >= 3'd3 && ecnt[2:0] <= 3'd6);
		end
	end

	// Request packet: low half in window 0, high half in window 1, inverted
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pkt               <= `DCS_PKT_W'(0);
			link.request_pins <= '1;
		end else if (tick) begin
			pkt               <= next_pkt;
			link.request_pins <= ~next_pkt[`DCS_REQ_W-1:0];
		end else if (ecnt[2:0] == 3'(`DCS_W1_EIGHTH - 3'd1)) begin
			link.request_pins <= ~pkt[`DCS_PKT_W-1:`DCS_REQ_W];
		end
	end

	// Write data held per issue cycle until every pin has sent it
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			slot_v <= '0;
		end else if (tick) begin
			slot_v[next_slot] <= accept && dcs_is_write(i_req_cmd);
		end
	end

	always_ff @(posedge i_clk) begin
		if (tick && accept && dcs_is_write(i_req_cmd)) begin
			slot_d[next_slot] <= i_req_data;
		end
	end

	// Each pin sends bit j at its offset plus j eighths, three cycles on
	always_ff @(posedge i_clk) begin
		logic [5:0] a;
		logic [2:0] cur;
		logic [2:0] prv;
		a   = 6'h00;
		cur = 3'h0;
		prv = 3'h0;
		if (i_rst) begin
			link.data_true_pins <= '1;
			link.data_comp_pins <= '1;
		end else begin
			for (int i = 0; i < DW; i++) begin
				a   = 6'(ecnt + 6'd1 - {3'b000, i_tx_offset[i*3 +: 3]} - `DCS_DATA_START);
				cur = a[5:3];
				prv = 3'(a[5:3] - 3'd1);
				if (slot_v[cur]) begin
					link.data_true_pins[i] <= slot_d[cur][i*16 + int'(a[2:0])];
					link.data_comp_pins[i] <= !slot_d[cur][i*16 + int'(a[2:0])];
				end else if (slot_v[prv]) begin
					link.data_true_pins[i] <= slot_d[prv][i*16 + 8 + int'(a[2:0])];
					link.data_comp_pins[i] <= !slot_d[prv][i*16 + 8 + int'(a[2:0])];
				end else begin
					link.data_true_pins[i] <= 1'b1;
					link.data_comp_pins[i] <= 1'b1;
				end
			end
		end
	end

endmodule // dcs_controller

// File: src/dcs_device.sv
// DRAM device end: finds the reference crossing, samples request windows
// and gathers write data bits at per-pin offsets.
// Assumes the controller end shares i_clk and keeps all command spacing.
`timescale 1ns/100ps
`include "dcs_defines.svh"

module dcs_device
	import dcs_pkg::*;
#(
	parameter int DW = 16
) (
	// Clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_rst,
	// Static per-pin receive offsets, measured at initialization
	input  wire logic [DW*3-1:0]        i_rx_offset,
	// Link
	dcs_link_if.dev                     link,
	// Decoded commands
	output logic                        o_cmd_valid,
	output dcs_cmd_type                 o_cmd,
	output logic [2:0]                  o_cmd_bank,
	output logic                        o_load_group,
	output logic                        o_refresh_group,
	// Received write data
	output logic                        o_wr_valid,
	output logic [DW*16-1:0]            o_wr_data,
	output logic [2:0]                  o_wr_bank,
	output logic                        o_wr_masked
);

	localparam int NB = 8;

	logic                  prev_true;
	logic                  fall;
	logic [5:0]            dec;
	logic [5:0]            cur_e;
	logic [`DCS_REQ_W-1:0] win0;
	logic [`DCS_PKT_W-1:0] rx_pkt;
	dcs_cmd_type           rx_cmd;
	logic [5:0]            done_e;
	logic [NB-1:0]         slot_v;
	logic [2:0]            slot_bank [NB];
	logic [NB-1:0]         slot_masked;
	logic [DW*16-1:0]      slot_d [NB];

	// Primary crossing: true phase falls while the complement is high
	assign fall   = prev_true && !link.clock_true_phase && link.clock_comp_phase;
	assign cur_e  = fall ? {3'(dec[5:3] + 3'd1), 3'b000} : 6'(dec + 6'd1);
	assign rx_pkt = {~link.request_pins, win0};
	assign rx_cmd = dcs_cmd_type'(rx_pkt[3:0]);
	assign done_e = 6'(cur_e - `DCS_DELIVER);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			prev_true <= 1'b0;
			dec       <= 6'h3f;
		end else begin
			prev_true <= link.clock_true_phase;
			dec       <= cur_e;
		end
	end

	// Window 0 at the crossing, window 1 half a cycle later
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			win0 <= '0;
		end else if (cur_e[2:0] == 3'd0) begin
			win0 <= ~link.request_pins;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_cmd_valid     <= 1'b0;
			o_cmd           <= cmd_nop;
			o_cmd_bank      <= 3'h0;
			o_load_group    <= 1'b0;
			o_refresh_group <= 1'b0;
		end else begin
			o_cmd_valid     <= cur_e[2:0] == `DCS_W1_EIGHTH && rx_cmd != cmd_nop;
			o_cmd           <= rx_cmd;
			o_cmd_bank      <= rx_pkt[6:4];
			o_load_group    <= cur_e[2:0] == `DCS_W1_EIGHTH && dcs_is_load(rx_cmd);
			o_refresh_group <= cur_e[2:0] == `DCS_W1_EIGHTH && dcs_is_refx(rx_cmd);
		end
	end

	// Pending writes by command cycle; a new write wins over a delivery clear
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			slot_v <= '0;
		end else begin
			if (done_e[2:0] == 3'd0) begin
				slot_v[done_e[5:3]] <= 1'b0;
			end
			if (cur_e[2:0] == `DCS_W1_EIGHTH && dcs_is_write(rx_cmd)) begin
				slot_v[cur_e[5:3]] <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (cur_e[2:0] == `DCS_W1_EIGHTH && dcs_is_write(rx_cmd)) begin
			slot_bank[cur_e[5:3]]   <= rx_pkt[6:4];
			slot_masked[cur_e[5:3]] <= rx_cmd == masked_column_write_cmd;
		end
	end

	// Bit j of a pin is taken at its offset plus j eighths
	always_ff @(posedge i_clk) begin
		logic [5:0] a;
		logic [2:0] cur;
		logic [2:0] prv;
		a   = 6'h00;
		cur = 3'h0;
		prv = 3'h0;
		for (int i = 0; i < DW; i++) begin
			a   = 6'(cur_e - {3'b000, i_rx_offset[i*3 +: 3]} - `DCS_DATA_START);
			cur = a[5:3];
			prv = 3'(a[5:3] - 3'd1);
			if (slot_v[cur]) begin
				slot_d[cur][i*16 + int'(a[2:0])] <= link.data_true_pins[i] && !link.data_comp_pins[i];
			end else if (slot_v[prv]) begin
				slot_d[prv][i*16 + 8 + int'(a[2:0])] <= link.data_true_pins[i] && !link.data_comp_pins[i];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_wr_valid  <= 1'b0;
			o_wr_data   <= '0;
			o_wr_bank   <= 3'h0;
			o_wr_masked <= 1'b0;
		end else begin
			o_wr_valid <= done_e[2:0] == 3'd0 && slot_v[done_e[5:3]];
			if (done_e[2:0] == 3'd0 && slot_v[done_e[5:3]]) begin
				o_wr_data   <= slot_d[done_e[5:3]];
				o_wr_bank   <= slot_bank[done_e[5:3]];
				o_wr_masked <= slot_masked[done_e[5:3]];
			end
		end
	end

endmodule // dcs_device

// File: tb/dcs_link_assertions.sv
// Checker on the link between controller and device ends.
// Assumes it sits beside the link interface, fed its signals by name.
`timescale 1ns/100ps

module dcs_link_assertions
	import dcs_pkg::*;
#(
	parameter int DW = 16
) (
	// Clock, reset, bin
	input  wire logic          i_clk,
	input  wire logic          i_rst,
	input  wire dcs_bin_type   i_bin,
	// Link
	input  wire logic          clock_true_phase,
	input  wire logic          clock_comp_phase,
	input  wire logic [11:0]   request_pins,
	input  wire logic [DW-1:0] data_true_pins,
	input  wire logic [DW-1:0] data_comp_pins
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	logic        prev;
	logic [5:0]  rd_age;
	logic [5:0]  ld_age;
	logic [5:0]  gp_age;
	logic [5:0]  wa [2];
	logic [3:0]  c;
	int          rw;
	int          wr;
	int          lr;
	wire         xing = prev && !clock_true_phase;
	wire         rise = !prev && clock_true_phase;
	wire         st = ~request_pins[4];
	wire         is_rd = xing && c == 4'h2;
	wire         is_wr = xing && (c == 4'h3 || c == 4'h4);
	wire         is_ld = xing && c >= 4'h6 && c <= 4'h8;
	wire         is_rx = xing && c >= 4'h9 && c <= 4'hb;

	assign c = ~request_pins[3:0];

	always_comb begin
		rw = (i_bin == bin_a) ? 8 : (i_bin == bin_d) ? 10 : 9;
		wr = (i_bin == bin_a) ? 9 : 10;
		lr = (i_bin == bin_a) ? 16 : (i_bin == bin_b) ? 20 : 24;
	end

	function automatic logic [5:0] age(input logic [5:0] a, input logic hit, input logic inc);
		return hit ? 6'h00 : (inc && a != 6'h3f) ? a + 6'h01 : a;
	endfunction

	// Ages in memory cycles, stepped at each rising true phase
	always_ff @(posedge i_clk) begin
		prev <= clock_true_phase;
		if (i_rst) begin
			rd_age <= 6'h3f;
			ld_age <= 6'h3f;
			gp_age <= 6'h3f;
			wa[0] <= 6'h3f;
			wa[1] <= 6'h3f;
		end else begin
			rd_age <= age(rd_age, is_rd, rise);
			ld_age <= age(ld_age, is_ld, rise);
			gp_age <= age(gp_age, is_ld || is_rx, rise);
			wa[0] <= age(wa[0], is_wr && !st, rise);
			wa[1] <= age(wa[1], is_wr && st, rise);
		end
	end

	a_comp_inverse: assert property (clock_comp_phase == !clock_true_phase)
		else $error("clock phases not complementary");
	a_clock_eighths: assert property ($fell(clock_true_phase) |=>
		!clock_true_phase [*3] ##1 clock_true_phase [*4] ##1 !clock_true_phase)
		else $error("clock phase pattern broken");
	a_request_hold: assert property (!xing && !rise |-> $stable(request_pins))
		else $error("request pins moved inside a window");
	a_request_upper: assert property (clock_true_phase |-> request_pins == 12'hfff)
		else $error("second window not all inverted zero");
	a_column_pair: assert property (is_rd |-> rd_age >= 6'h02)
		else $error("reads closer than two cycles");
	a_read_write: assert property (is_wr |-> rd_age >= rw)
		else $error("read to write too close");
	a_write_read_same: assert property (is_rd |-> wa[st] >= wr)
		else $error("same set write to read too close");
	a_write_read_cross: assert property (is_rd |-> wa[!st] >= wr ||
		(wa[!st] >= 6'h02 && !(wa[!st] inside {6'h03, 6'h05, 6'h07})))
		else $error("cross set write to read spacing illegal");
	a_load_spacing: assert property (is_ld |-> gp_age >= lr)
		else $error("load too close to load or refresh");
	a_refresh_spacing: assert property (is_rx |-> ld_age >= lr)
		else $error("refresh too close to load");
	a_data_idle: assert property (wa[0] >= 6'h07 && wa[1] >= 6'h07 |->
		&data_true_pins && &data_comp_pins)
		else $error("data pins not idle");
	a_pair_never_low: assert property (&(data_true_pins | data_comp_pins))
		else $error("data pair low on both phases");

	c_write: cover property (is_wr);
	c_load: cover property (is_ld);
	c_cross: cover property (is_rd && wa[!st] < wr);
endmodule // dcs_link_assertions

// File: tb/dram_command_spacing_and_capture_tb_top.sv
// Both link ends joined; a spacing and capture model checks every result.
// Assumes package, interface and both ends are compiled first.
`timescale 1ns/100ps

module dram_command_spacing_and_capture_tb_top
	import dcs_pkg::*;
;
	typedef struct {dcs_cmd_type c; logic [2:0] b; int t; logic [255:0] d;} dcs_exp_type;
	logic         i_clk;
	logic         i_rst;
	logic         i_req_valid;
	logic         o_req_ready;
	dcs_bin_type  i_bin;
	logic [47:0]  i_tx_offset;
	dcs_cmd_type  i_req_cmd;
	logic [2:0]   i_req_bank;
	logic [255:0] i_req_data;
	logic         o_cmd_valid, o_load_group, o_refresh_group, o_wr_valid, o_wr_masked;
	dcs_cmd_type  o_cmd;
	logic [2:0]   o_cmd_bank, o_wr_bank;
	logic [255:0] o_wr_data;
	logic [31:0]  rs = 32'h0000001c;
	int           fail_count = 0, check_count = 0, cyc = 0, bn;
	int           l_any, l_rd, l_ld, l_gp, l_ws [2], l_rdb [8], l_wrb [8], l_act [8];
	int           t_rw [4] = '{8, 9, 9, 10}, t_wr [4] = '{9, 10, 10, 10}, t_rdp [4] = '{3, 4, 4, 6};
	int           t_wrp [4] = '{10, 12, 12, 14}, t_lr [4] = '{16, 20, 24, 24}, t_rc [4] = '{16, 20, 24, 30};
	dcs_exp_type  cq [$], wq [$];
	dcs_cmd_type  fc [14] = '{column_write_cmd, column_read_cmd, column_read_cmd, masked_column_write_cmd,
		column_read_cmd, row_precharge_cmd, row_precharge_cmd, refresh_reg_load_0, refresh_reg_load_1,
		refresh_activate_cmd, refresh_reg_load_2, refresh_increment_activate_cmd, refresh_precharge_cmd,
		row_activate_cmd};
	logic [2:0]   fb [14] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h2, 3'h2, 3'h1, 3'h0, 3'h0, 3'h5, 3'h0, 3'h5, 3'h6, 3'h5};

	dcs_link_if #(.DW(16)) dcs_link_if_i ();

	dcs_controller #(.DW(16)) dcs_controller_i (.i_clk(i_clk), .i_rst(i_rst), .i_bin(i_bin),
		.i_tx_offset(i_tx_offset), .i_req_valid(i_req_valid), .i_req_cmd(i_req_cmd), .i_req_bank(i_req_bank),
		.i_req_data(i_req_data), .o_req_ready(o_req_ready), .link(dcs_link_if_i));
	dcs_device #(.DW(16)) dcs_device_i (.i_clk(i_clk), .i_rst(i_rst), .i_rx_offset(i_tx_offset),
		.link(dcs_link_if_i), .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd), .o_cmd_bank(o_cmd_bank),
		.o_load_group(o_load_group), .o_refresh_group(o_refresh_group), .o_wr_valid(o_wr_valid),
		.o_wr_data(o_wr_data), .o_wr_bank(o_wr_bank), .o_wr_masked(o_wr_masked));
	dcs_link_assertions #(.DW(16)) dcs_link_assertions_i (.i_clk(i_clk), .i_rst(i_rst), .i_bin(i_bin),
		.clock_true_phase(dcs_link_if_i.clock_true_phase), .clock_comp_phase(dcs_link_if_i.clock_comp_phase),
		.request_pins(dcs_link_if_i.request_pins), .data_true_pins(dcs_link_if_i.data_true_pins),
		.data_comp_pins(dcs_link_if_i.data_comp_pins));

	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction

	function automatic int mx(int a, int b);
		return a > b ? a : b;
	endfunction

	// First memory cycle at which the command is legal
	function automatic int earliest(dcs_cmd_type c, logic [2:0] b);
		int e;
		int d;
		e = l_any + 1;
		if (c == column_read_cmd) begin
			e = mx(mx(e, l_rd + 2), mx(l_ws[b[0]] + t_wr[bn], l_ws[!b[0]] + 2));
			d = e - l_ws[!b[0]];
			while (d < t_wr[bn] && (d == 3 || d == 5 || d == 7)) d++;
			e = l_ws[!b[0]] + d;
		end
		if (c inside {column_write_cmd, masked_column_write_cmd})
			e = mx(e, mx(l_rd + t_rw[bn], mx(l_ws[0], l_ws[1]) + 2));
		if (c == row_precharge_cmd)
			e = mx(e, mx(l_rdb[b] + t_rdp[bn], l_wrb[b] + t_wrp[bn]));
		if (c inside {[refresh_reg_load_0:refresh_reg_load_2]})
			e = mx(e, l_gp + t_lr[bn]);
		if (c inside {[refresh_activate_cmd:refresh_precharge_cmd]})
			e = mx(e, l_ld + t_lr[bn]);
		if (c inside {row_activate_cmd, refresh_activate_cmd, refresh_increment_activate_cmd})
			e = mx(e, l_act[b] + t_rc[bn]);
		return e;
	endfunction

	task automatic chk(string n, logic [255:0] s, logic [255:0] e);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %0h seen %0h", n, e, s);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic issue(dcs_cmd_type c, logic [2:0] b);
		int e;
		int m;
		int k;
		logic [255:0] d;
		e = earliest(c, b);
		for (k = 0; k < 8; k++) d[k*32+:32] = rnd();
		@(posedge i_clk);
		i_req_valid <= 1'b1;
		i_req_cmd <= c;
		i_req_bank <= b;
		i_req_data <= d;
		k = 0;
		do begin
			@(negedge i_clk);
			k++;
		end while (o_req_ready !== 1'b1 && k < 400);
		@(posedge i_clk);
		i_req_valid <= 1'b0;
		@(negedge i_clk);
		m = cyc >>> 3;
		if (l_any > -500)
			chk("spacing", m, e);
		cq.push_back('{c, b, cyc, d});
		if (c inside {column_write_cmd, masked_column_write_cmd}) begin
			wq.push_back('{c, b, cyc, d});
			l_ws[b[0]] = m;
			l_wrb[b] = m;
		end
		if (c == column_read_cmd) begin
			l_rd = m;
			l_rdb[b] = m;
		end
		if (c inside {[refresh_reg_load_0:refresh_reg_load_2]})
			l_ld = m;
		if (c inside {[refresh_reg_load_0:refresh_precharge_cmd]})
			l_gp = m;
		if (c inside {row_activate_cmd, refresh_activate_cmd, refresh_increment_activate_cmd})
			l_act[b] = m;
		l_any = m;
	endtask

	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	always @(posedge i_clk) cyc <= cyc + 1;

	always @(negedge i_clk) begin : mon
		dcs_exp_type x;
		if (o_cmd_valid === 1'b1)
			chk("cmd_expected", cq.size() > 0, 1'b1);
		if (o_wr_valid === 1'b1)
			chk("wr_expected", wq.size() > 0, 1'b1);
		if (o_cmd_valid === 1'b1 && cq.size() > 0) begin
			x = cq.pop_front();
			chk("cmd", o_cmd, x.c);
			chk("cmd_bank", o_cmd_bank, x.b);
			chk("cmd_delay", cyc - x.t, 5);
			chk("load_group", o_load_group, x.c inside {[refresh_reg_load_0:refresh_reg_load_2]});
			chk("refresh_group", o_refresh_group, x.c inside {[refresh_activate_cmd:refresh_precharge_cmd]});
		end
		if (o_wr_valid === 1'b1 && wq.size() > 0) begin
			x = wq.pop_front();
			chk("wr_data", o_wr_data, x.d);
			chk("wr_bank", o_wr_bank, x.b);
			chk("wr_masked", o_wr_masked, x.c == masked_column_write_cmd);
			chk("wr_delay", cyc - x.t, 48);
		end
	end

	initial begin
		#240000;
		fail_count++;
		tally_and_finish();
	end

	initial begin : main
		int n;
		logic [63:0] o;
		logic [31:0] r;
		i_rst = 1'b1;
		i_req_valid = 1'b0;
		i_req_cmd = cmd_nop;
		i_req_bank = 3'h0;
		i_req_data = '0;
		i_bin = bin_a;
		i_tx_offset = '0;
		for (bn = 0; bn < 4; bn++) begin
			o = {rnd(), rnd()};
			@(posedge i_clk);
			i_rst <= 1'b1;
			i_bin <= dcs_bin_type'(bn);
			i_tx_offset <= o[47:0];
			repeat (5) @(posedge i_clk);
			i_rst <= 1'b0;
			l_any = -1000;
			l_rd = -1000;
			l_ld = -1000;
			l_gp = -1000;
			l_ws = '{-1000, -1000};
			l_rdb = '{8{-1000}};
			l_wrb = '{8{-1000}};
			l_act = '{8{-1000}};
			for (n = 0; n < 14; n++) issue(fc[n], fb[n]);
			for (n = 0; n < 12; n++) begin
				r = rnd();
				issue(dcs_cmd_type'(r[3:0] % 4'hb + 4'h1), r[6:4]);
			end
			repeat (80) @(posedge i_clk);
		end
		chk("cmd_left", cq.size(), 0);
		chk("wr_left", wq.size(), 0);
		tally_and_finish();
	end
endmodule // dram_command_spacing_and_capture_tb_top
